// File: inc/ras_pkg.sv
package ras_pkg;
	localparam int PC_W = 13;
	localparam int LEVELS = 8;
	localparam int PTR_W = 3;
	localparam int DEPTH_W = 4;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int IDX_LSB = 2;
	localparam logic [7:0] IDX_POINTER = 8'hdf;
	localparam logic [7:0] IDX_STATUS = 8'he0;
	localparam logic [7:0] IDX_ENTRY_BASE = 8'hf0;
	localparam int IRQ_EN_BIT = 7;
	localparam int PTR_MSB = 2;
	localparam int HI_BITS = 5;
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_UNF_BIT = 1;
	localparam int STAT_DEPTH_LSB = 4;
	localparam logic [PTR_W-1:0] PTR_RESET = 3'h7;
	localparam logic [DEPTH_W-1:0] DEPTH_FULL = 4'h8;
	localparam logic [PC_W-1:0] ENTRY_RESET = 13'h0000;
	localparam logic IRQ_EN_RESET = 1'b0;
endpackage : ras_pkg

// File: verilog/ras_ptr.sv
`timescale 1ns/1ps
module ras_ptr
	import ras_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic pop,
	input wire logic load,
	input wire logic [PTR_W-1:0] load_val,
	output logic [PTR_W-1:0] ptr,
	output logic [DEPTH_W-1:0] depth,
	output logic ovf_evt,
	output logic unf_evt
);
	typedef struct packed {
		logic [PTR_W-1:0] ptr;
		logic [DEPTH_W-1:0] depth;
	} ptr_state_t;

	ptr_state_t s_q;
	ptr_state_t s_d;

	// Depth counts modulo 16 so that the pointer always equals seven minus depth
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.ptr = s_q.ptr - 3'h1; // see R4 see R14
			s_d.depth = s_q.depth + 4'h1; // see R6
		end else if (pop) begin
			s_d.ptr = s_q.ptr + 3'h1; // see R4 see R14
			s_d.depth = s_q.depth - 4'h1;
		end else if (load) begin
			s_d.ptr = load_val; // see R2
			s_d.depth = {1'b0, PTR_RESET - load_val};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q.ptr <= PTR_RESET; // see R6
			s_q.depth <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ptr = s_q.ptr;
	assign depth = s_q.depth;
	assign ovf_evt = push && (s_q.depth >= DEPTH_FULL); // see R13
	assign unf_evt = pop && !push && (s_q.depth == '0);
endmodule : ras_ptr

// File: verilog/ras_entries.sv
`timescale 1ns/1ps
module ras_entries
	import ras_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic [PTR_W-1:0] push_idx,
	input wire logic [PC_W-1:0] push_pc,
	input wire logic [PTR_W-1:0] pop_idx,
	output logic [PC_W-1:0] pop_pc,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [PTR_W-1:0] bus_idx,
	input wire logic [7:0] bus_data,
	output logic [7:0] rd_lo,
	output logic [7:0] rd_hi
);
	typedef struct packed {
		logic [LEVELS-1:0][PC_W-1:0] ent;
	} ent_state_t;

	ent_state_t s_q;
	ent_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.ent[push_idx] = push_pc; // see R5 see R1
		end else begin
			if (wr_lo) begin
				s_d.ent[bus_idx][7:0] = bus_data; // see R10
			end
			if (wr_hi) begin
				s_d.ent[bus_idx][PC_W-1:8] = bus_data[HI_BITS-1:0]; // see R3
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < LEVELS; i++) begin
				s_q.ent[i] <= ENTRY_RESET; // see R10
			end
		end else begin
			s_q <= s_d;
		end
	end

	assign pop_pc = s_q.ent[pop_idx];
	assign rd_lo = s_q.ent[bus_idx][7:0];
	assign rd_hi = {3'h0, s_q.ent[bus_idx][PC_W-1:8]}; // see R3
endmodule : ras_entries

// File: verilog/return_address_stack.sv
// Operation
// R1 - Eight saved program counter values for calls and interrupt service.
// R2 - Three-bit pointer in bits 2..0 of its register selects the active entry.
// R3 - Entry is 13 bits: high byte holds bits 12..8, low byte bits 7..0.
// R4 - Push decrements the pointer, pop increments it; last in, first out.
// R5 - Push current program counter on a call or interrupt entry.
// R6 - After k pushes entries 0..k-1 used, pointer reads 7-k; empty is 111.
// R7 - Interrupt return and subroutine return both pop the matching entry.
// R8 - Pop returns the newest entry and leaves pointer at next free place.
// R9 - Pointer and all entry bytes are mapped registers; entries at f0..ff.
// R10 - Entries are software readable and writable, reset to zero.
// R11 - Pointer register bit 7 is the global interrupt enable, reset 0.
// R12 - Software should write 00000111 to the pointer register at start.
// R13 - Ninth nested push wraps pointer to 110 and is flagged as overflow.
// R14 - Pointer wraps modulo eight on push and pop, never saturates.
`timescale 1ns/1ps
module return_address_stack
	import ras_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [ADDR_W-1:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [DATA_W-1:0] WRITEDATA,
	input wire logic [3:0] BYTEENABLE,
	output logic [DATA_W-1:0] READDATA,
	output logic WAITREQUEST,
	input wire logic CALL_PUSH,
	input wire logic IRQ_PUSH,
	input wire logic [PC_W-1:0] PUSH_PC,
	input wire logic SUBROUTINE_RETURN_INSN,
	input wire logic RETURN_FROM_INTERRUPT_INSN,
	output logic [PC_W-1:0] RETURN_PC,
	output logic RETURN_VALID,
	output logic GLOBAL_IRQ_ENABLE,
	output logic [PTR_W-1:0] POINTER_BITS,
	output logic OVERFLOW,
	output logic UNDERFLOW
);
	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic [PC_W-1:0] rtn_pc;
		logic rtn_valid;
		logic irq_en;
		logic ovf;
		logic unf;
	} top_state_t;

	function automatic logic is_entry(input logic [7:0] idx);
		is_entry = (idx >= IDX_ENTRY_BASE);
	endfunction : is_entry

	top_state_t s_q;
	top_state_t s_d;

	logic push;
	logic pop;
	logic bus_req;
	logic take;
	logic wr;
	logic [7:0] idx;
	logic ptr_load;
	logic ent_wr_lo;
	logic ent_wr_hi;
	logic [PTR_W-1:0] ptr;
	logic [DEPTH_W-1:0] depth;
	logic ovf_evt;
	logic unf_evt;
	logic [PC_W-1:0] pop_pc;
	logic [7:0] rd_lo;
	logic [7:0] rd_hi;
	logic [7:0] rd;

	assign push = CALL_PUSH || IRQ_PUSH; // see R5
	assign pop = (SUBROUTINE_RETURN_INSN || RETURN_FROM_INTERRUPT_INSN) && !push; // see R7
	assign bus_req = READ || WRITE;
	assign take = s_q.ack && bus_req;
	assign wr = take && WRITE && BYTEENABLE[0];
	assign idx = ADDRESS[ADDR_W-1:IDX_LSB];
	assign ptr_load = wr && (idx == IDX_POINTER) && !push && !pop; // see R9
	assign ent_wr_lo = wr && is_entry(idx) && !idx[0]; // see R9 see R10
	assign ent_wr_hi = wr && is_entry(idx) && idx[0];

	ras_ptr u_ptr (
		.clk(CLK),
		.rst_n(RESET_N),
		.push(push),
		.pop(pop),
		.load(ptr_load),
		.load_val(WRITEDATA[PTR_MSB:0]),
		.ptr(ptr),
		.depth(depth),
		.ovf_evt(ovf_evt),
		.unf_evt(unf_evt)
	);

	// Push writes the slot the inverted pointer names; pop reads the slot one below it
	ras_entries u_entries (
		.clk(CLK),
		.rst_n(RESET_N),
		.push(push),
		.push_idx(~ptr), // see R6
		.push_pc(PUSH_PC),
		.pop_idx(~(ptr + 3'h1)), // see R8
		.pop_pc(pop_pc),
		.wr_lo(ent_wr_lo),
		.wr_hi(ent_wr_hi),
		.bus_idx(idx[3:1]),
		.bus_data(WRITEDATA[7:0]),
		.rd_lo(rd_lo),
		.rd_hi(rd_hi)
	);

	always_comb begin
		rd = 8'h00;
		if (idx == IDX_POINTER) begin
			rd[PTR_MSB:0] = ptr; // see R2
			rd[IRQ_EN_BIT] = s_q.irq_en;
		end else if (idx == IDX_STATUS) begin
			rd[STAT_OVF_BIT] = s_q.ovf;
			rd[STAT_UNF_BIT] = s_q.unf;
			rd[7:STAT_DEPTH_LSB] = depth;
		end else if (is_entry(idx)) begin
			rd = idx[0] ? rd_hi : rd_lo;
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.ack = bus_req && !s_q.ack;
		if (bus_req && !s_q.ack) begin
			s_d.rdata = rd;
		end
		s_d.rtn_valid = pop; // see R8
		if (pop) begin
			s_d.rtn_pc = pop_pc; // see R7
		end
		if (wr && (idx == IDX_POINTER)) begin
			s_d.irq_en = WRITEDATA[IRQ_EN_BIT]; // see R11
		end
		if (wr && (idx == IDX_STATUS)) begin
			if (WRITEDATA[STAT_OVF_BIT]) begin
				s_d.ovf = 1'b0;
			end
			if (WRITEDATA[STAT_UNF_BIT]) begin
				s_d.unf = 1'b0;
			end
		end
		// A new event beats a clear in the same cycle
		if (ovf_evt) begin
			s_d.ovf = 1'b1; // see R13
		end
		if (unf_evt) begin
			s_d.unf = 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_q.ack <= 1'b0;
			s_q.rdata <= 8'h00;
			s_q.rtn_pc <= ENTRY_RESET;
			s_q.rtn_valid <= 1'b0;
			s_q.irq_en <= IRQ_EN_RESET; // see R11
			s_q.ovf <= 1'b0;
			s_q.unf <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign WAITREQUEST = bus_req && !s_q.ack;
	assign READDATA = {24'h000000, s_q.rdata};
	assign RETURN_PC = s_q.rtn_pc;
	assign RETURN_VALID = s_q.rtn_valid;
	assign GLOBAL_IRQ_ENABLE = s_q.irq_en;
	assign POINTER_BITS = ptr;
	assign OVERFLOW = s_q.ovf;
	assign UNDERFLOW = s_q.unf;

	property p_push_dec;
		@(posedge CLK) disable iff (!RESET_N)
		push |=> ptr == $past(ptr) - 3'h1;
	endproperty
	a_push_dec: assert property (p_push_dec) else $error("push did not decrement"); // see R4

	property p_pop_inc;
		@(posedge CLK) disable iff (!RESET_N)
		pop |=> ptr == $past(ptr) + 3'h1;
	endproperty
	a_pop_inc: assert property (p_pop_inc) else $error("pop did not increment"); // see R4

	property p_lifo;
		@(posedge CLK) disable iff (!RESET_N)
		push ##1 pop |=> RETURN_VALID && (RETURN_PC == $past(PUSH_PC, 2));
	endproperty
	a_lifo: assert property (p_lifo) else $error("pop did not return last push"); // see R8

	property p_depth_ptr;
		@(posedge CLK) disable iff (!RESET_N)
		ptr == PTR_RESET - depth[PTR_W-1:0];
	endproperty
	a_depth_ptr: assert property (p_depth_ptr) else $error("pointer not seven minus depth"); // see R6

	property p_wrap;
		@(posedge CLK) disable iff (!RESET_N)
		push && (ptr == 3'h0) |=> ptr == PTR_RESET;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // see R14

	property p_ovf;
		@(posedge CLK) disable iff (!RESET_N)
		push && (depth == DEPTH_FULL) |=> OVERFLOW && (ptr == 3'h6);
	endproperty
	a_ovf: assert property (p_ovf) else $error("ninth push not flagged"); // see R13

	property p_irq_en;
		@(posedge CLK) disable iff (!RESET_N)
		wr && (idx == IDX_POINTER) |=> GLOBAL_IRQ_ENABLE == $past(WRITEDATA[IRQ_EN_BIT]);
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("interrupt enable not written"); // see R11

	property p_ptr_write;
		@(posedge CLK) disable iff (!RESET_N)
		ptr_load |=> ptr == $past(WRITEDATA[PTR_MSB:0]);
	endproperty
	a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost"); // see R2

	property p_hi_zero;
		@(posedge CLK) disable iff (!RESET_N)
		take && READ && is_entry(idx) && idx[0] |-> READDATA[7:HI_BITS] == 3'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("high byte upper bits set"); // see R3

	property p_wait;
		@(posedge CLK) disable iff (!RESET_N)
		WAITREQUEST |=> !WAITREQUEST;
	endproperty
	a_wait: assert property (p_wait) else $error("waitrequest held too long");

	property p_ret_valid;
		@(posedge CLK) disable iff (!RESET_N)
		pop |=> RETURN_VALID;
	endproperty
	a_ret_valid: assert property (p_ret_valid) else $error("pop gave no return pulse"); // see R8

	property p_no_ret;
		@(posedge CLK) disable iff (!RESET_N)
		!pop |=> !RETURN_VALID;
	endproperty
	a_no_ret: assert property (p_no_ret) else $error("return pulse without pop"); // see R8

	property p_ret_hold;
		@(posedge CLK) disable iff (!RESET_N)
		!pop |=> $stable(RETURN_PC);
	endproperty
	a_ret_hold: assert property (p_ret_hold) else $error("return value moved without pop"); // see R8

	property p_pop_wrap;
		@(posedge CLK) disable iff (!RESET_N)
		pop && (ptr == PTR_RESET) |=> ptr == 3'h0;
	endproperty
	a_pop_wrap: assert property (p_pop_wrap) else $error("pointer did not wrap on pop"); // see R14

	property p_ovf_hold;
		@(posedge CLK) disable iff (!RESET_N)
		OVERFLOW && !(wr && (idx == IDX_STATUS) && WRITEDATA[STAT_OVF_BIT]) |=> OVERFLOW;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost"); // see R13

	property p_push_store;
		@(posedge CLK) disable iff (!RESET_N)
		push |=> pop_pc == $past(PUSH_PC);
	endproperty
	a_push_store: assert property (p_push_store) else $error("pushed value not on top"); // see R5

	property p_gie_hold;
		@(posedge CLK) disable iff (!RESET_N)
		!(wr && (idx == IDX_POINTER)) |=> $stable(GLOBAL_IRQ_ENABLE);
	endproperty
	a_gie_hold: assert property (p_gie_hold) else $error("interrupt enable moved unasked"); // see R11

	property p_cov_push;
		@(posedge CLK) disable iff (!RESET_N)
		IRQ_PUSH ##1 CALL_PUSH;
	endproperty
	c_cov_push: cover property (p_cov_push);

	property p_cov_ovf;
		@(posedge CLK) disable iff (!RESET_N)
		ovf_evt;
	endproperty
	c_cov_ovf: cover property (p_cov_ovf);

	property p_cov_pop;
		@(posedge CLK) disable iff (!RESET_N)
		pop && RETURN_FROM_INTERRUPT_INSN;
	endproperty
	c_cov_pop: cover property (p_cov_pop);

	property p_cov_load;
		@(posedge CLK) disable iff (!RESET_N)
		ptr_load;
	endproperty
	c_cov_load: cover property (p_cov_load);
endmodule : return_address_stack

// File: bench/cpu_seq_model.sv
`timescale 1ns/1ps
module cpu_seq_model (
	input wire logic CLK,
	output logic CALL_PUSH,
	output logic IRQ_PUSH,
	output logic SUBROUTINE_RETURN_INSN,
	output logic RETURN_FROM_INTERRUPT_INSN,
	output logic [12:0] PUSH_PC
);
	initial begin
		{CALL_PUSH, IRQ_PUSH, SUBROUTINE_RETURN_INSN, RETURN_FROM_INTERRUPT_INSN} = 4'h0;
		PUSH_PC = 13'h0000;
	end
	// One pulse pattern per cycle, so back-to-back ops need no gap
	task op(input logic [3:0] kind, input logic [12:0] pc);
		{CALL_PUSH, IRQ_PUSH, SUBROUTINE_RETURN_INSN, RETURN_FROM_INTERRUPT_INSN} <= kind;
		PUSH_PC <= pc;
		@(posedge CLK);
	endtask : op
endmodule : cpu_seq_model

// File: bench/return_address_stack_tb.sv
`timescale 1ns/1ps
module return_address_stack_tb;
	import ras_pkg::*;
	logic CLK = 1'b0, RESET_N = 1'b0, READ = 1'b0, WRITE = 1'b0;
	logic [ADDR_W-1:0] ADDRESS = '0;
	logic [DATA_W-1:0] WRITEDATA = '0, READDATA;
	logic [3:0] BYTEENABLE = 4'h0;
	logic WAITREQUEST, CALL_PUSH, IRQ_PUSH, SUBROUTINE_RETURN_INSN, RETURN_FROM_INTERRUPT_INSN;
	logic [PC_W-1:0] PUSH_PC, RETURN_PC, rpc;
	logic RETURN_VALID, GLOBAL_IRQ_ENABLE, OVERFLOW, UNDERFLOW;
	logic [PTR_W-1:0] POINTER_BITS, ptr = 3'h7;
	logic [PC_W-1:0] ent [8];
	logic [7:0] rd;
	logic ovf = 1'b0, unf = 1'b0, pv = 1'b0, rv = 1'b0, be = 1'b1;
	int errors = 0, checked = 0, depth = 0;
	return_address_stack uut (.CLK(CLK), .RESET_N(RESET_N), .ADDRESS(ADDRESS), .READ(READ),
		.WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
		.WAITREQUEST(WAITREQUEST), .CALL_PUSH(CALL_PUSH), .IRQ_PUSH(IRQ_PUSH),
		.PUSH_PC(PUSH_PC), .SUBROUTINE_RETURN_INSN(SUBROUTINE_RETURN_INSN),
		.RETURN_FROM_INTERRUPT_INSN(RETURN_FROM_INTERRUPT_INSN), .RETURN_PC(RETURN_PC),
		.RETURN_VALID(RETURN_VALID), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
		.POINTER_BITS(POINTER_BITS), .OVERFLOW(OVERFLOW), .UNDERFLOW(UNDERFLOW));
	cpu_seq_model cpu (.CLK(CLK), .CALL_PUSH(CALL_PUSH), .IRQ_PUSH(IRQ_PUSH),
		.SUBROUTINE_RETURN_INSN(SUBROUTINE_RETURN_INSN),
		.RETURN_FROM_INTERRUPT_INSN(RETURN_FROM_INTERRUPT_INSN), .PUSH_PC(PUSH_PC));
	initial begin
		forever #2.5 CLK = ~CLK;
	end
	task chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_reg
	task chk_cpu(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_cpu
	task test_done;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	// Holds the request until waitrequest is seen low, then updates the model
	task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		ADDRESS <= {idx, 2'b00};
		READ <= !wr;
		WRITE <= wr;
		WRITEDATA <= {24'h0, wd};
		BYTEENABLE <= {3'h0, be};
		do begin
			@(posedge CLK);
			n++;
		end while (WAITREQUEST !== 1'b0 && n < 50);
		if (n >= 50) errors++;
		rd = READDATA[7:0];
		if (wr && be && idx == IDX_POINTER) begin
			ptr = wd[2:0];
			depth = 7 - wd[2:0];
		end
		if (wr && be && idx >= IDX_ENTRY_BASE && !idx[0]) ent[idx[3:1]][7:0] = wd;
		if (wr && be && idx >= IDX_ENTRY_BASE && idx[0]) ent[idx[3:1]][12:8] = wd[4:0];
		if (wr && be && idx == IDX_STATUS && wd[STAT_OVF_BIT]) ovf = 1'b0;
		if (wr && be && idx == IDX_STATUS && wd[STAT_UNF_BIT]) unf = 1'b0;
		READ <= 1'b0;
		WRITE <= 1'b0;
		@(posedge CLK);
	endtask : bus
	// Reference stack, stepped on the same edge that takes a push or pop
	always @(posedge CLK) if (RESET_N) begin
		if (pv) chk_cpu({6'h0, OVERFLOW, UNDERFLOW, 2'h0, POINTER_BITS}, {6'h0, ovf, unf, 2'h0, ptr});
		if (rv) chk_cpu(RETURN_PC, rpc);
		chk_cpu({12'h0, RETURN_VALID}, {12'h0, rv});
		pv = 1'b0;
		rv = 1'b0;
		if (CALL_PUSH || IRQ_PUSH) begin
			ent[7 - ptr] = PUSH_PC;
			if (depth >= 8) ovf = 1'b1;
			depth = (depth + 1) % 16;
			ptr = ptr - 3'h1;
			pv = 1'b1;
		end else if (SUBROUTINE_RETURN_INSN || RETURN_FROM_INTERRUPT_INSN) begin
			if (depth == 0) unf = 1'b1;
			depth = (depth + 15) % 16;
			ptr = ptr + 3'h1;
			rpc = ent[7 - ptr];
			rv = 1'b1;
			pv = 1'b1;
		end
	end
	initial begin
		#20000;
		errors++;
		test_done;
	end
	initial begin
		for (int i = 0; i < 8; i++) ent[i] = ENTRY_RESET;
		void'($urandom(86));
		repeat (10) @(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
		bus(1'b0, IDX_POINTER, 8'h00);
		chk_reg(rd, 8'h07);
		bus(1'b0, 8'hf0, 8'h00);
		chk_reg(rd, 8'h00);
		bus(1'b0, 8'hff, 8'h00);
		chk_reg(rd, 8'h00);
		bus(1'b0, 8'h10, 8'h00);
		chk_reg(rd, 8'h00);
		$display("test reset done");
		bus(1'b1, IDX_POINTER, 8'h87);
		bus(1'b0, IDX_POINTER, 8'h00);
		chk_reg(rd, 8'h87);
		chk_reg({7'h0, GLOBAL_IRQ_ENABLE}, 8'h01);
		$display("test pointer write done");
		for (int i = 0; i < 9; i++) cpu.op((i % 2) ? 4'h4 : 4'h8, 13'($urandom));
		cpu.op(4'h0, 13'h0000);
		bus(1'b0, IDX_POINTER, 8'h00);
		chk_reg(rd, {5'h10, ptr});
		for (int n = 0; n < 16; n++) begin
			bus(1'b0, IDX_ENTRY_BASE + 8'(n), 8'h00);
			chk_reg(rd, n[0] ? {3'h0, ent[n / 2][12:8]} : ent[n / 2][7:0]);
		end
		$display("test push done");
		bus(1'b1, 8'hf6, 8'ha5);
		bus(1'b1, 8'hf7, 8'hff);
		for (int i = 0; i < 10; i++) cpu.op((i % 2) ? 4'h1 : 4'h2, 13'h0000);
		cpu.op(4'h0, 13'h0000);
		cpu.op(4'h0, 13'h0000);
		chk_reg({7'h0, GLOBAL_IRQ_ENABLE}, 8'h01);
		$display("test pop done");
		bus(1'b0, IDX_STATUS, 8'h00);
		chk_reg(rd, {4'(depth), 2'h0, unf, ovf});
		bus(1'b1, IDX_STATUS, 8'h03);
		bus(1'b0, IDX_STATUS, 8'h00);
		chk_reg(rd, {4'(depth), 2'h0, unf, ovf});
		be = 1'b0;
		bus(1'b1, IDX_POINTER, 8'h07);
		be = 1'b1;
		bus(1'b0, IDX_POINTER, 8'h00);
		chk_reg(rd, {5'h10, ptr});
		bus(1'b1, IDX_POINTER, 8'h07);
		cpu.op(4'h8, 13'($urandom));
		cpu.op(4'h2, 13'h0000);
		cpu.op(4'h0, 13'h0000);
		bus(1'b0, IDX_POINTER, 8'h00);
		chk_reg(rd, {5'h00, ptr});
		$display("test status done");
		test_done;
	end
endmodule : return_address_stack_tb
